// ### etb_pkg.sv
// constants and types of the external test bus master, plus its input
// synchroniser; assumes one pclk domain and a tester-made link clock
`timescale 1ns/1ns

package etb_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WRITE = 8'h08;
  localparam logic [7:0] OFS_READ = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int CTRL_ENTER = 0;
  localparam int CTRL_EXIT = 1;
  localparam int CTRL_CLRERR = 2;

  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_TEST_ACKNOWLEDGE = 2;
  localparam int STAT_FULL = 3;
  localparam int STAT_RDVALID = 4;
  localparam int STAT_ERR = 5;

  localparam logic [1:0] RD_TAIL_CYCLES = 2'h2;

  localparam int PCLK_PERIOD_NS = 20;
  localparam int EXTERNAL_TEST_CLOCK_PERIOD_NS = 160;
  localparam int EXTERNAL_TEST_CLOCK_HALF_CYC = EXTERNAL_TEST_CLOCK_PERIOD_NS / (2 * PCLK_PERIOD_NS);

  // request line codes, {request_a, request_b}
  localparam logic [1:0] TREQ_ADDR = 2'h3;
  localparam logic [1:0] TREQ_WRITE = 2'h2;
  localparam logic [1:0] TREQ_READ = 2'h1;
  localparam logic [1:0] TREQ_EXIT = 2'h0;

  typedef enum logic [1:0] {
    VEC_ADDR = 2'b00,
    VEC_WRITE = 2'b01,
    VEC_READ = 2'b10,
    VEC_EXIT = 2'b11
  } etb_vec_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTER = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_EXITING = 2'b11
  } etb_state_e;

endpackage

module etb_sync
  import etb_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### etb_test_bus_master.sv
// tester-side master of the external test bus: runs vectors ordered over
// apb, makes the test clock by a divider; device pins are plain ports
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns

module etb_test_bus_master
  import etb_pkg::*;
#(
  parameter int HALF_CYC = EXTERNAL_TEST_CLOCK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic external_test_clock,
  output logic test_request_a,
  output logic test_request_b,
  input wire logic test_acknowledge,
  input wire logic [31:0] test_data_bus_in,
  output logic [31:0] test_data_bus_out,
  output logic test_data_bus_oe_n
);

  logic [32:0] sync_q;
  logic test_acknowledge_s;
  logic [31:0] test_data_bus_s;
  logic [7:0] div_cnt;
  logic tick, run, toggle, rise, fall, done;
  etb_state_e state;
  logic cur_valid, nxt_valid, prev_read, rd_valid, err;
  etb_vec_e cur_type, nxt_type, req_type, q_last;
  logic [31:0] cur_data, nxt_data, rdata;
  logic [1:0] rd_tail, q_tail;
  logic acc, wr, rd, vec_wr, type_ok, accept, enter_wr, mapped;

  etb_sync #(.W(33)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({test_acknowledge, test_data_bus_in}),
    .q(sync_q)
  );

  assign test_acknowledge_s = sync_q[32];
  assign test_data_bus_s = sync_q[31:0];

  // test clock divider; in ST_ACTIVE the clock is stopped high while no next vector is
  // known, since the request lines could not announce anything honest
  assign tick = ce && (div_cnt == 8'(HALF_CYC - 1));
  assign run = (state == ST_ENTER) || (state == ST_EXITING) ||
               ((state == ST_ACTIVE) && (nxt_valid || !external_test_clock));
  assign toggle = tick && (run || ((state == ST_IDLE) && external_test_clock));
  assign rise = toggle && !external_test_clock;
  assign fall = toggle && external_test_clock;
  // a vector completes at a rising edge unless the device is waiting
  assign done = rise && (state == ST_ACTIVE) && (!cur_valid || test_acknowledge_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
    end else if (ce) begin
      if (tick) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_test_clock <= 1'b0;
    end else if (toggle) begin
      external_test_clock <= !external_test_clock;
    end
  end

  // apb decode
  assign acc = psel && penable && pready && ce;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign enter_wr = wr && (paddr == OFS_CTRL) && pwdata[CTRL_ENTER];
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) ||
                  (paddr == OFS_WRITE) || (paddr == OFS_READ) ||
                  (paddr == OFS_RDATA) || (paddr == OFS_STATUS);

  always_comb begin
    vec_wr = 1'b0;
    req_type = VEC_ADDR;
    if (wr) begin
      unique case (paddr)
        OFS_ADDR: begin
          vec_wr = 1'b1;
          req_type = VEC_ADDR;
        end
        OFS_WRITE: begin
          vec_wr = 1'b1;
          req_type = VEC_WRITE;
        end
        OFS_READ: begin
          vec_wr = 1'b1;
          req_type = VEC_READ;
        end
        OFS_CTRL: begin
          vec_wr = pwdata[CTRL_EXIT];
          req_type = VEC_EXIT;
        end
        default: vec_wr = 1'b0;
      endcase
    end
  end

  // order check on queued vectors: nothing but an address first, two
  // address vectors after reads, and an address cycle just before exit
  always_comb begin
    type_ok = 1'b0;
    unique case (req_type)
      VEC_ADDR: type_ok = 1'b1;
      VEC_WRITE: type_ok = (q_tail == 2'h0) && !(q_last == VEC_READ);
      VEC_READ: type_ok = (q_tail == 2'h0) || (q_last == VEC_READ);
      VEC_EXIT: type_ok = (q_last == VEC_ADDR) && (q_tail == 2'h0);
    endcase
    if (!cur_valid && !nxt_valid) begin
      type_ok = (req_type == VEC_ADDR);
    end
  end

  assign accept = vec_wr && (state == ST_ACTIVE) && type_ok &&
                  (!nxt_valid || done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      unique case (state)
        ST_IDLE: begin
          if (enter_wr) begin
            state <= ST_ENTER;
          end
        end
        ST_ENTER: begin
          if (rise && test_acknowledge_s) begin
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (done && nxt_valid && (nxt_type == VEC_EXIT)) begin
            state <= ST_EXITING;
          end
        end
        ST_EXITING: begin
          if (rise && !test_acknowledge_s) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // current vector and the one announced for the following cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_valid <= 1'b0;
      cur_type <= VEC_ADDR;
      cur_data <= 32'h0000_0000;
      nxt_valid <= 1'b0;
      nxt_type <= VEC_ADDR;
      nxt_data <= 32'h0000_0000;
    end else if (ce) begin
      if (enter_wr && (state == ST_IDLE)) begin
        cur_valid <= 1'b0;
        nxt_valid <= 1'b0;
      end else begin
        if (done) begin
          cur_valid <= nxt_valid;
          cur_type <= nxt_type;
          cur_data <= nxt_data;
        end
        if (accept) begin
          nxt_valid <= 1'b1;
          nxt_type <= req_type;
          nxt_data <= pwdata;
        end else if (done) begin
          nxt_valid <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_last <= VEC_ADDR;
      q_tail <= 2'h0;
    end else if (ce) begin
      if (enter_wr && (state == ST_IDLE)) begin
        q_last <= VEC_ADDR;
        q_tail <= 2'h0;
      end else if (accept) begin
        q_last <= req_type;
        if (req_type == VEC_READ) begin
          q_tail <= RD_TAIL_CYCLES;
        end else if (q_tail != 2'h0) begin
          q_tail <= q_tail - 2'h1;
        end
      end
    end
  end

  // address cycles still owed to bus turnaround after a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_tail <= 2'h0;
      prev_read <= 1'b0;
    end else if (ce) begin
      if (enter_wr && (state == ST_IDLE)) begin
        rd_tail <= 2'h0;
        prev_read <= 1'b0;
      end else if (done && cur_valid) begin
        prev_read <= (cur_type == VEC_READ);
        if (cur_type == VEC_READ) begin
          rd_tail <= RD_TAIL_CYCLES;
        end else if (rd_tail != 2'h0) begin
          rd_tail <= rd_tail - 2'h1;
        end
      end
    end
  end

  // read data shows up one cycle after its read vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 32'h0000_0000;
      rd_valid <= 1'b0;
    end else if (ce) begin
      if (done && cur_valid && prev_read) begin
        rdata <= test_data_bus_s;
        rd_valid <= 1'b1;
      end else if (rd && (paddr == OFS_RDATA)) begin
        rd_valid <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
    end else if (ce) begin
      if ((vec_wr && !accept) || (enter_wr && (state != ST_IDLE))) begin
        err <= 1'b1;
      end else if (wr && (paddr == OFS_CTRL) && pwdata[CTRL_CLRERR]) begin
        err <= 1'b0;
      end
    end
  end

  // pins change at the falling test clock edge, half a period of setup, except test_request_a rising on the enter write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_request_a <= 1'b0;
      test_request_b <= 1'b0;
    end else if (ce) begin
      if (enter_wr && (state == ST_IDLE)) begin
        test_request_a <= 1'b1;
        test_request_b <= 1'b0;
      end else if (fall) begin
        unique case (state)
          ST_IDLE, ST_EXITING: begin
            test_request_a <= 1'b0;
            test_request_b <= 1'b0;
          end
          ST_ENTER: begin
            test_request_a <= 1'b1;
            test_request_b <= 1'b0;
          end
          ST_ACTIVE: begin
            if (nxt_valid) begin
              {test_request_a, test_request_b} <= treq_code(nxt_type);
            end
          end
        endcase
      end
    end
  end

  function automatic logic [1:0] treq_code(input etb_vec_e t);
    logic [1:0] c;
    c = TREQ_EXIT;
    unique case (t)
      VEC_ADDR: c = TREQ_ADDR;
      VEC_WRITE: c = TREQ_WRITE;
      VEC_READ: c = TREQ_READ;
      VEC_EXIT: c = TREQ_EXIT;
    endcase
    return c;
  endfunction

  // the bus floats in read cycles and in the two turnaround cycles after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_data_bus_out <= 32'h0000_0000;
      test_data_bus_oe_n <= 1'b1;
    end else if (ce && fall) begin
      test_data_bus_out <= cur_data;
      if ((state == ST_ACTIVE) && cur_valid &&
          ((cur_type == VEC_WRITE) ||
           ((cur_type == VEC_ADDR) && (rd_tail == 2'h0)))) begin
        test_data_bus_oe_n <= 1'b0;
      end else begin
        test_data_bus_oe_n <= 1'b1;
      end
    end
  end

  // apb slave: one wait-free access cycle, data prepared in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) begin
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= 32'h0000_0000;
        if (!pwrite && (paddr == OFS_RDATA)) begin
          prdata <= rdata;
        end else if (!pwrite && (paddr == OFS_STATUS)) begin
          prdata[STAT_STATE_LSB +: 2] <= state;
          prdata[STAT_TEST_ACKNOWLEDGE] <= test_acknowledge_s;
          prdata[STAT_FULL] <= nxt_valid;
          prdata[STAT_RDVALID] <= rd_valid;
          prdata[STAT_ERR] <= err;
        end
      end else if (acc) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  read_float_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall && (state == ST_ACTIVE) && cur_valid && (cur_type == VEC_READ)
    |=> test_data_bus_oe_n)
    else $error("tester drove the data bus in a read cycle");

  tail_float_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall && (state == ST_ACTIVE) && cur_valid && (cur_type == VEC_ADDR) &&
    (rd_tail != 2'h0)
    |=> test_data_bus_oe_n)
    else $error("tester drove the data bus during turnaround");

  write_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall && (state == ST_ACTIVE) && cur_valid && (cur_type == VEC_WRITE)
    |=> !test_data_bus_oe_n && (test_data_bus_out == $past(cur_data)))
    else $error("write data not driven in its cycle");

  announce_addr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall && (state == ST_ACTIVE) && nxt_valid && (nxt_type == VEC_ADDR)
    |=> test_request_a && test_request_b)
    else $error("next address vector not announced");

  wait_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise && (state == ST_ACTIVE) && cur_valid && !test_acknowledge_s
    |=> cur_valid && $stable(cur_type) && $stable(cur_data))
    else $error("vector changed while the device waited");

  entry_req_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == ST_ENTER) |-> test_request_a && !test_request_b)
    else $error("request a not held during entry");

  entry_ack_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == ST_ENTER) ##1 (state == ST_ACTIVE) |-> $past(test_acknowledge_s))
    else $error("test mode taken without acknowledge");

  first_addr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == ST_ACTIVE) && !cur_valid && nxt_valid
    |-> (nxt_type == VEC_ADDR))
    else $error("first vector is not an address vector");

  exit_lines_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == ST_EXITING) && fall |=> !test_request_a && !test_request_b)
    else $error("request lines not low while exiting");

endmodule

// ### etb_dev_model.sv
// behavioural model of the on-chip test interface controller (device side)
// assumes the tester makes the link clock and pins change at its falling edges
`timescale 1ns/1ns

module etb_dev_model
  import etb_pkg::*;
#(
  parameter int GRANT_CYC = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic external_test_clock,
  input wire logic test_request_a,
  input wire logic test_request_b,
  output logic test_acknowledge,
  input wire logic [31:0] test_data_bus_out,
  input wire logic test_data_bus_oe_n,
  output logic [31:0] test_data_bus_in,
  input wire logic stall
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] addr, dev_d, last_bus, b;
  logic [2:0] size;
  logic [3:0] prot;
  logic lock, inc, got_addr, dev_oe;
  logic [1:0] req, cur, prevt, mode;
  int grant, turn, fault = 0;

  assign req = {test_request_a, test_request_b};
  assign b = test_data_bus_in;
  // undriven bus toggles so a released line never looks like held data
  assign test_data_bus_in = !test_data_bus_oe_n ? test_data_bus_out :
                            dev_oe ? dev_d : ~last_bus;

  // 8-bit incrementer, wraps at 256 units of the current size
  function automatic logic [31:0] step(input logic [31:0] a);
    logic [31:0] bnd;
    bnd = 32'h100 << size[1:0];
    return (a & ~(bnd - 1)) | ((a + (32'h1 << size[1:0])) & (bnd - 1));
  endfunction

  always @(posedge pclk) begin
    last_bus <= test_data_bus_in;
    if (!test_data_bus_oe_n && dev_oe) fault++;
  end

  // internal bus runs from the tester's clock once in test mode
  always @(posedge external_test_clock or negedge presetn) begin
    if (!presetn) begin
      mode <= 2'h0;
      test_acknowledge <= 1'b0;
      dev_oe <= 1'b0;
      grant <= 0;
      turn <= 0;
      cur <= TREQ_EXIT;
      prevt <= TREQ_EXIT;
    end else if (mode == 2'h0) begin
      test_acknowledge <= 1'b0;
      if (test_request_a) grant <= grant + 1;
      if (grant == GRANT_CYC) begin
        test_acknowledge <= 1'b1;
        mode <= 2'h1;
        size <= 3'h2;
        prot <= 4'h3;
        lock <= 1'b0;
        inc <= 1'b0;
        got_addr <= 1'b0;
      end
    end else if (mode == 2'h1) begin
      if (req == TREQ_ADDR) begin
        cur <= req;
        prevt <= TREQ_EXIT;
        mode <= 2'h2;
      end
    end else if (!test_acknowledge) begin
      test_acknowledge <= 1'b1;
    end else begin
      prevt <= cur;
      cur <= req;
      if (stall && req == TREQ_WRITE) test_acknowledge <= 1'b0;
      if (cur != TREQ_ADDR && cur != TREQ_EXIT && !got_addr) fault++;
      case (cur)
        TREQ_ADDR: begin
          if (turn != 0) begin
            if (turn == 2) dev_oe <= 1'b0;
            turn <= turn - 1;
          end else if (prevt == TREQ_ADDR && req != TREQ_ADDR) begin
            if (b[0]) begin
              size <= {1'b0, b[3:2]};
              lock <= b[4];
              prot <= {b[10:9], b[6:5]};
              inc <= b[7];
            end
          end else begin
            addr <= b;
            got_addr <= 1'b1;
          end
        end
        TREQ_WRITE: begin
          mem[addr] = b;
          addr <= inc ? step(addr) : addr;
        end
        TREQ_READ: begin
          dev_d <= mem.exists(addr) ? mem[addr] : 32'h0;
          dev_oe <= 1'b1;
          turn <= 2;
          addr <= inc ? step(addr) : addr;
        end
        default: begin
          test_acknowledge <= 1'b0;
          mode <= 2'h0;
          grant <= 0;
          dev_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### testbench.sv
// self-checking bench: apb master drives the test bus master, the device
// model sits on the link; expected values come from the vector layout
`timescale 1ns/1ns

module testbench
  import etb_pkg::*;
();
  logic pclk, presetn, psel, penable, pwrite, stall, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, test_data_bus_in, test_data_bus_out;
  logic pready, pslverr, external_test_clock, test_acknowledge;
  logic test_request_a, test_request_b, test_data_bus_oe_n;
  int errors = 0, checks = 0, cyc = 0;

  etb_test_bus_master #(.HALF_CYC(4)) i_dut (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .external_test_clock, .test_request_a,
    .test_request_b, .test_acknowledge, .test_data_bus_in,
    .test_data_bus_out, .test_data_bus_oe_n);

  etb_dev_model i_dev (
    .pclk, .presetn, .external_test_clock, .test_request_a,
    .test_request_b, .test_acknowledge, .test_data_bus_out,
    .test_data_bus_oe_n, .test_data_bus_in, .stall);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      end_of_test;
    end
  end

  task end_of_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits for pready without a cycle limit; the global timeout ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_state(input logic [1:0] s);
    do apb(1'b0, OFS_STATUS, 32'h0); while (r[1:0] !== s);
  endtask

  // the design holds one queued vector, so wait until its slot is free
  task vec(input logic [7:0] a, input logic [31:0] d);
    do apb(1'b0, OFS_STATUS, 32'h0); while (r[STAT_FULL] !== 1'b0);
    apb(1'b1, a, d);
  endtask

  // link clock parks high once nothing more is queued
  task settle;
    int n;
    n = 0;
    do apb(1'b0, OFS_STATUS, 32'h0); while (r[STAT_FULL] !== 1'b0);
    while (n < 12) begin
      @(posedge pclk);
      n = external_test_clock ? n + 1 : 0;
    end
  endtask

  task seq(input logic [31:0] a, c, d0, d1);
    vec(OFS_ADDR, a);
    vec(OFS_ADDR, c);
    vec(OFS_WRITE, d0);
    vec(OFS_WRITE, d1);
    vec(OFS_ADDR, 32'h0);
    settle;
  endtask

  task t_reset;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    // a vector queued outside test mode is refused and flagged
    apb(1'b1, OFS_WRITE, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, r[STAT_ERR]}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(r, 32'h0);
  endtask

  task t_enter;
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_state(2'h2);
    chk({31'h0, r[STAT_TEST_ACKNOWLEDGE]}, 32'h1);
    chk({25'h0, i_dev.size, i_dev.prot}, 32'h23);
    chk({31'h0, i_dev.inc}, 32'h0);
  endtask

  task t_burst;
    stall <= 1'b1;
    seq(32'h100, 32'h89, 32'h11111111, 32'h22222222);
    stall <= 1'b0;
    chk(i_dev.mem[32'h100], 32'h11111111);
    chk(i_dev.mem[32'h104], 32'h22222222);
  endtask

  task t_fixed;
    seq(32'h200, 32'h5, 32'ha5a5a5a5, 32'h5a5a5a5a);
    chk(i_dev.mem[32'h200], 32'h5a5a5a5a);
    chk({29'h0, i_dev.size}, 32'h1);
    seq(32'h300, 32'h88, 32'h33, 32'h44);
    chk(i_dev.mem[32'h300], 32'h44);
  endtask

  task t_wrap;
    seq(32'h3fc, 32'h99, 32'h55, 32'h66);
    chk(i_dev.mem[32'h0], 32'h66);
    chk({31'h0, i_dev.lock}, 32'h1);
    seq(32'h5ff, 32'h6e1, 32'h77, 32'h88);
    chk(i_dev.mem[32'h500], 32'h88);
    chk({28'h0, i_dev.prot}, 32'hf);
  endtask

  task t_read;
    i_dev.mem[32'h400] = 32'hcafe0123;
    vec(OFS_ADDR, 32'h400);
    vec(OFS_ADDR, 32'h9);
    vec(OFS_READ, 32'h0);
    vec(OFS_ADDR, 32'h0);
    vec(OFS_ADDR, 32'h0);
    vec(OFS_WRITE, 32'h12345678);
    vec(OFS_ADDR, 32'h0);
    settle;
    apb(1'b0, OFS_RDATA, 32'h0);
    chk(r, 32'hcafe0123);
    chk(i_dev.mem[32'h400], 32'h12345678);
    chk(i_dev.fault, 32'h0);
  endtask

  task t_exit;
    vec(OFS_ADDR, 32'h0);
    vec(OFS_CTRL, 32'h2);
    wait_state(2'h0);
    chk({31'h0, r[STAT_TEST_ACKNOWLEDGE]}, 32'h0);
    chk({31'h0, r[STAT_ERR]}, 32'h0);
    chk({31'h0, test_acknowledge}, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    stall = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_enter;
    t_burst;
    t_fixed;
    t_wrap;
    t_read;
    t_exit;
    end_of_test;
  end
endmodule
